// File: flash_rd_ecc.sv
// Purpose: Flash read path with ECC error reporting, profiling and a Wishbone register slave.
// Assumes: Classic Wishbone, 32-bit data, one flash read outstanding at a time.
// Notes: Interrupt output is high while any unmasked status bit is set.
// Function
// RULE1: Bus-two correctable error sets its flag. The code sets it only for errors in the special area.
// RULE2: Profiling keeps bus-two flag clear.
// RULE3: Profiling counts errors, flags at threshold.
// RULE4: Profiling enable bit enters profiling.
// RULE5: Software keeps force-fail enables off when profiling.
// RULE6: Error address and position name culprit.
// RULE7: Unaligned bank-tail reads complete without abort.
// RULE8: Bank-crossing reads complete without abort.
// RULE9: Software avoids zero wait above 20MHz.
// RULE10: Software may leave last fifteen bytes unused.
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module flash_rd_ecc
	import flash_rd_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Flash read requests.
	input  wire rd_req_t     rd_req_i,
	output logic             rd_done_o,
	output logic             rd_abort_o,
	// ECC check results.
	input  wire ecc_evt_t    ecc_i,
	// Fault injection to the ECC checker.
	output logic             force_one_fail_enable_o,
	output logic             force_zero_fail_enable_o,
	// Interrupt.
	output logic             irq_o
);

	// Control and status state.
	logic [31:0]      ctrl;
	logic [31:0]      next_ctrl;
	logic [ST_W-1:0]  status;
	logic [ST_W-1:0]  next_status;
	logic [ST_W-1:0]  mask;
	logic [ST_W-1:0]  next_mask;
	logic [15:0]      thresh;
	logic [15:0]      next_thresh;
	logic [31:0]      err_addr;
	logic [31:0]      next_err_addr;
	logic [7:0]       err_pos;
	logic [7:0]       next_err_pos;
	logic [31:0]      next_dat;
	logic [31:0]      thr_word;
	logic             next_ack;
	logic             wr_en;
	logic [ST_W-1:0]  set_bits;
	logic             profiling_enable;
	logic             prof_hit;
	logic [15:0]      prof_count;
	logic             cor_evt;
	reg_sel_t         rsel;

	// Address decode, shared by read and write paths.
	function automatic reg_sel_t decode(input logic [7:0] a);
		if (a == OFS_CTRL) begin
			decode = SEL_CTRL;
		end else if (a == OFS_STATUS) begin
			decode = SEL_STATUS;
		end else if (a == OFS_MASK) begin
			decode = SEL_MASK;
		end else if (a == OFS_THRESH) begin
			decode = SEL_THRESH;
		end else if (a == OFS_COUNT) begin
			decode = SEL_COUNT;
		end else if (a == OFS_ERR_ADDR) begin
			decode = SEL_ADDR;
		end else if (a == OFS_ERR_POS) begin
			decode = SEL_POS;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// Byte-lane merge for writes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	assign rsel  = decode(adr_i);
	// A write lands on the edge at which the master sees ack, never one edge early.
	assign wr_en = cyc_i && stb_i && we_i && ack_o;

	// RULE4: enable bit drives mode
	assign profiling_enable         = ctrl[CTRL_PROF_EN];
	assign force_one_fail_enable_o  = ctrl[CTRL_ONE_FAIL];
	assign force_zero_fail_enable_o = ctrl[CTRL_ZERO_FAIL];
	assign cor_evt                  = ecc_i.valid && ecc_i.correctable;

	// Profiling counter.
	ecc_profile u_prof (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.enable_i    (profiling_enable),
		.threshold_i (thresh),
		.cor_evt_i   (cor_evt),
		.count_o     (prof_count),
		.hit_o       (prof_hit)
	);

	// Read sequencing; only bank-crossing reads take two beats, tail reads that stay in the bank take one, and none abort.
	flash_bank_split u_split (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.req_i      (rd_req_i),
		.wait_i     (ctrl[CTRL_WAIT_LSB +: WAIT_W]),
		.done_o     (rd_done_o),
		.two_beat_o ()
	);

	// RULE7: no abort generated
	assign rd_abort_o = 1'b0;

	// Event sources; in profiling the bus-two flag is held off so software sees only one cause.
	always_comb begin
		set_bits = '0;
		if (cor_evt) begin
			if (profiling_enable) begin
				// RULE2: profiling reports via flag
				set_bits[ST_PROF_FLG] = prof_hit;
			end else if (ecc_i.bus2 && ecc_i.special_area) begin
				// RULE1: bus-two correctable flag
				set_bits[ST_BUS2_COR] = 1'b1;
			end else if (!ecc_i.bus2) begin
				set_bits[ST_BUS1_COR] = 1'b1;
			end
		end
	end

	// Register next values; hardware set wins over a write-one clear in the same cycle.
	always_comb begin
		next_ctrl     = ctrl;
		next_mask     = mask;
		next_thresh   = thresh;
		next_status   = status;
		next_err_addr = err_addr;
		next_err_pos  = err_pos;
		thr_word      = merge({16'h0, thresh}, dat_i, sel_i);
		if (wr_en) begin
			if (rsel == SEL_CTRL) begin
				next_ctrl = merge(ctrl, dat_i, sel_i);
			end else if (rsel == SEL_MASK && sel_i[0]) begin
				next_mask = dat_i[ST_W-1:0];
			end else if (rsel == SEL_THRESH) begin
				next_thresh = thr_word[15:0];
			end else if (rsel == SEL_STATUS && sel_i[0]) begin
				next_status = status & ~dat_i[ST_W-1:0];
			end
		end
		next_status = next_status | set_bits;
		// RULE6: capture causing access
		if (cor_evt && (set_bits != '0 || profiling_enable)) begin
			next_err_addr = ecc_i.addr;
			next_err_pos  = ecc_i.bit_pos;
		end
	end

	// Read data and acknowledge; every access answers in one cycle, unmapped reads zero.
	always_comb begin
		next_ack = cyc_i && stb_i && !ack_o;
		next_dat = 32'h0000_0000;
		case (rsel)
			SEL_CTRL:   next_dat = ctrl;
			SEL_STATUS: next_dat = {29'h0, status};
			SEL_MASK:   next_dat = {29'h0, mask};
			SEL_THRESH: next_dat = {16'h0, thresh};
			SEL_COUNT:  next_dat = {16'h0, prof_count};
			SEL_ADDR:   next_dat = err_addr;
			SEL_POS:    next_dat = {24'h0, err_pos};
			default:    next_dat = 32'h0000_0000;
		endcase
	end

	// Registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= CTRL_RESET;
			status   <= '0;
			mask     <= '0;
			thresh   <= THRESH_RESET;
			err_addr <= '0;
			err_pos  <= '0;
			ack_o    <= 1'b0;
			dat_o    <= '0;
		end else begin
			ctrl     <= next_ctrl;
			status   <= next_status;
			mask     <= next_mask;
			thresh   <= next_thresh;
			err_addr <= next_err_addr;
			err_pos  <= next_err_pos;
			ack_o    <= next_ack;
			dat_o    <= next_dat;
		end
	end

	// Level interrupt from unmasked sticky bits.
	assign irq_o = |(status & mask);

	// Bus-two error in the special area outside profiling must show in the status one cycle later.
	a_bus2_sets: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
		(cor_evt && !profiling_enable && ecc_i.bus2 && ecc_i.special_area) |=> status[ST_BUS2_COR])
		else $error("Bus-two correctable flag not set.");

	// No new bus-two flag while profiling.
	a_bus2_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		(profiling_enable && !status[ST_BUS2_COR]) |=> !status[ST_BUS2_COR])
		else $error("Bus-two flag set during profiling.");

	// Threshold hit in profiling raises the profiling flag.
	a_prof_flag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		(profiling_enable && cor_evt && ({1'b0, prof_count} + 17'h1 >= {1'b0, thresh})) |=> status[ST_PROF_FLG])
		else $error("Profiling flag missed at threshold.");

	// Writing the enable bit enters profiling on the next cycle.
	a_enter_prof: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
		(wr_en && rsel == SEL_CTRL && sel_i[0] && dat_i[CTRL_PROF_EN]) |=> profiling_enable)
		else $error("Profiling mode not entered.");

	// Captured address is the reporting access, not an earlier one.
	a_err_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		(cor_evt && set_bits[ST_BUS2_COR]) |=> (err_addr == $past(ecc_i.addr)))
		else $error("Error address does not match the causing access.");

	// Abort seen low at least once within three cycles of any read request.
	a_no_abort: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
		rd_req_i.valid |-> ##[0:3] !rd_abort_o)
		else $error("Read aborted.");

	// Ack lasts exactly one cycle.
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("Ack held too long.");

	// Interrupt is high while the bus-two status bit is set and unmasked.
	a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		(status[ST_BUS2_COR] && mask[ST_BUS2_COR]) |-> irq_o)
		else $error("Interrupt missing for unmasked bit.");

	// A standing request is answered on the next edge.
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("Ack missing after request.");

	// No ack without a request standing.
	a_ack_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("Ack without request.");

	// A first-bus error outside profiling shows in its own status bit.
	a_bus1_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		(cor_evt && !profiling_enable && !ecc_i.bus2) |=> status[ST_BUS1_COR])
		else $error("Bus-one correctable flag not set.");

	// Profiling leaves the bus-one flag alone as well, so the profiling flag is the only report.
	a_bus1_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
		(profiling_enable && !status[ST_BUS1_COR]) |=> !status[ST_BUS1_COR])
		else $error("Bus-one flag set during profiling.");

	// The bit position is captured with the reporting access.
	a_err_pos: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		(cor_evt && set_bits[ST_BUS2_COR]) |=> (err_pos == $past(ecc_i.bit_pos)))
		else $error("Error position does not match the causing access.");

	// In profiling every event is captured, so the flag never points at an older access.
	a_prof_addr: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
		(cor_evt && profiling_enable) |=> (err_addr == $past(ecc_i.addr)))
		else $error("Profiling error address is stale.");

	// The counter is held at zero outside profiling.
	a_count_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		!profiling_enable |=> (prof_count == 16'h0))
		else $error("Profiling counter not cleared.");

	// Read completion is a single-cycle pulse.
	a_done_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		rd_done_o |=> !rd_done_o)
		else $error("Read done held too long.");

	// A write-one clear takes a bit down unless a new event sets it again.
	a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && rsel == SEL_STATUS && sel_i[0] && dat_i[ST_BUS1_COR] && !set_bits[ST_BUS1_COR])
		|=> !status[ST_BUS1_COR])
		else $error("Status bit not cleared by write.");

endmodule
`default_nettype wire

// File: flash_rd_pkg.sv
// Purpose: Shared constants and types for the flash read path with ECC profiling.
// Assumes: 32-bit Wishbone register bus, 250 MHz clock.
// Notes: Register offsets are byte addresses of aligned words.
package flash_rd_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h04;
	localparam logic [7:0] OFS_MASK      = 8'h08;
	localparam logic [7:0] OFS_THRESH    = 8'h0C;
	localparam logic [7:0] OFS_COUNT     = 8'h10;
	localparam logic [7:0] OFS_ERR_ADDR  = 8'h14;
	localparam logic [7:0] OFS_ERR_POS   = 8'h18;

	// Control field positions.
	localparam int CTRL_PROF_EN  = 0;
	localparam int CTRL_ONE_FAIL = 1;
	localparam int CTRL_ZERO_FAIL = 2;
	localparam int CTRL_WAIT_LSB = 4;
	localparam int WAIT_W        = 4;

	// Status field positions (same layout in the mask).
	localparam int ST_BUS1_COR = 0;
	localparam int ST_BUS2_COR = 1;
	localparam int ST_PROF_FLG = 2;
	localparam int ST_W        = 3;

	// Reset values.
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0010;
	localparam logic [15:0] THRESH_RESET = 16'hFFFF;

	// Bank geometry: a bank ends at the last 64 KiB page offset 0xFFFF.
	localparam logic [15:0] BANK_TAIL_FIRST = 16'hFFF1;
	localparam logic [15:0] BANK_TAIL_LAST  = 16'hFFFF;

	// Single-cycle mode frequency limit and the bus clock.
	localparam int SINGLE_CYCLE_MAX_MHZ = 20;
	localparam int CLK_MHZ              = 250;

	// A flash read request from either bus.
	typedef struct packed {
		logic        valid;
		logic        bus2;
		logic [31:0] addr;
		logic [1:0]  size;
	} rd_req_t;

	// One ECC check result on the flash side.
	typedef struct packed {
		logic        valid;
		logic        correctable;
		logic        bus2;
		logic        special_area;
		logic [31:0] addr;
		logic [7:0]  bit_pos;
	} ecc_evt_t;

	// Decoded register select.
	typedef enum logic [2:0] {
		SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_THRESH, SEL_COUNT, SEL_ADDR, SEL_POS, SEL_NONE
	} reg_sel_t;

endpackage

// File: flash_bank_split.sv
// Purpose: Splits a read into one or two beats so tail-of-bank and bank-crossing reads never abort.
// Assumes: Request held until done_o; flash answers after the programmed wait states.
// Notes: Bank index is address bit 16 upward; non power-of-two banks change nothing here.
`timescale 1ns/100ps
`default_nettype none
module flash_bank_split
	import flash_rd_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Request side.
	input  wire rd_req_t           req_i,
	input  wire logic [WAIT_W-1:0] wait_i,
	// Result side.
	output logic                   done_o,
	output logic                   two_beat_o
);

	typedef enum logic [1:0] {IDLE, BEAT1, BEAT2, DONE} split_st_t;

	split_st_t           st;
	split_st_t           next_st;
	logic [WAIT_W-1:0]   cnt;
	logic [WAIT_W-1:0]   next_cnt;
	logic                split;
	logic                next_split;
	logic [2:0]          nbytes;
	logic [16:0]         end_ofs;

	// Bytes covered by the access, and whether its last byte leaves the 64 KiB page.
	always_comb begin
		nbytes  = (req_i.size == 2'd2) ? 3'd4 : ((req_i.size == 2'd1) ? 3'd2 : 3'd1);
		end_ofs = {1'b0, req_i.addr[15:0]} + {14'h0, nbytes} - 17'h1;
	end

	// Sequencing: a crossing read is served as two flash beats, each with its own wait.
	always_comb begin
		next_st    = st;
		next_cnt   = cnt;
		next_split = split;
		case (st)
			IDLE: begin
				if (req_i.valid) begin
					// RULE7: tail reads split only if they cross the bank
					next_split = end_ofs[16] || (req_i.addr[15:0] >= BANK_TAIL_FIRST && nbytes > 3'd1
						&& req_i.addr[15:0] <= BANK_TAIL_LAST && end_ofs[16]);
					next_cnt = wait_i;
					next_st  = BEAT1;
				end
			end
			BEAT1: begin
				if (cnt == '0) begin
					next_cnt = wait_i;
					// RULE8: crossing gets second beat
					next_st  = split ? BEAT2 : DONE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			BEAT2: begin
				if (cnt == '0) begin
					next_st = DONE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_st = IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st    <= IDLE;
			cnt   <= '0;
			split <= 1'b0;
		end else begin
			st    <= next_st;
			cnt   <= next_cnt;
			split <= next_split;
		end
	end

	assign done_o     = (st == DONE);
	assign two_beat_o = split;

	// Every accepted read finishes: done within wait plus a fixed bound, never dropped.
	// RULE8: no read is abandoned
	a_split_completes: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
		(st == IDLE && req_i.valid) |-> ##[2:40] done_o)
		else $error("Split read did not complete.");

endmodule
`default_nettype wire

// File: ecc_profile.sv
// Purpose: Correctable-error counter with threshold for profiling mode.
// Assumes: One ECC event per cycle at most.
// Notes: Counter saturates; it clears when profiling is left.
`timescale 1ns/100ps
`default_nettype none
module ecc_profile
	import flash_rd_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control.
	input  wire logic        enable_i,
	input  wire logic [15:0] threshold_i,
	input  wire logic        cor_evt_i,
	// Results.
	output logic [15:0]      count_o,
	output logic             hit_o
);

	logic [15:0] next_count;

	// Count correctable events only while profiling.
	always_comb begin
		next_count = count_o;
		hit_o      = 1'b0;
		if (!enable_i) begin
			next_count = '0;
		end else if (cor_evt_i) begin
			// RULE3: count and compare
			if (count_o != 16'hFFFF) begin
				next_count = count_o + 16'h1;
			end
			// Widened sum so that a saturated counter still meets the threshold.
			hit_o = (({1'b0, count_o} + 17'h1) >= {1'b0, threshold_i});
		end
	end

	// Counter register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= '0;
		end else begin
			count_o <= next_count;
		end
	end

	// A counted event never goes without a step of the counter below saturation.
	a_count_steps: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		(enable_i && cor_evt_i && count_o != 16'hFFFF) |=> (count_o == $past(count_o) + 16'h1))
		else $error("Profiling counter did not step.");

endmodule
`default_nettype wire

// File: flash_master_model.sv
// Purpose: Master model that issues flash reads and presents ECC check results.
// Assumes: One read outstanding; the request is held until done is sampled high.
// Notes: Released lines carry inverted values, except the read's bus2 bit, which stays low; a stale value can never pass for a live one.
`timescale 1ns/100ps
`default_nettype none
module flash_master_model
	import flash_rd_pkg::*;
(
	// Clock.
	input  wire logic    clk_i,
	// Read answer.
	input  wire logic    rd_done_i,
	input  wire logic    rd_abort_i,
	// Requests and events.
	output var rd_req_t  rd_req_o,
	output var ecc_evt_t ecc_o
);
	// Both lines start idle.
	initial begin
		rd_req_o = '0;
		ecc_o = '0;
	end

	// Holds one read until done, noting any abort on the way.
	task automatic read(input logic [31:0] a, input logic [1:0] sz, output logic done, output logic abrt,
		output int cyc);
		int n;
		n = 0;
		abrt = 1'b0;
		rd_req_o <= '{1'b1, 1'b0, a, sz};
		do begin
			@(posedge clk_i);
			n++;
			abrt = abrt | rd_abort_i;
		end while (rd_done_i !== 1'b1 && n < 40);
		done = rd_done_i;
		cyc = n;
		rd_req_o <= '{1'b0, 1'b0, ~a, ~sz};
		@(posedge clk_i);
	endtask

	// Presents one correctable result for a single cycle.
	task automatic inject(input logic b2, input logic sp, input logic [31:0] a, input logic [7:0] p);
		ecc_o <= '{1'b1, 1'b1, b2, sp, a, p};
		@(posedge clk_i);
		ecc_o <= '{1'b0, 1'b0, ~b2, ~sp, ~a, ~p};
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the flash read path with ECC profiling.
// Assumes: Register access through classic Wishbone single cycles.
// Notes: Wait states stay at one throughout, since single-cycle reads are unsafe at this clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import flash_rd_pkg::*;

	logic       clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, done, abort, f_one, f_zero;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	rd_req_t    rd_req;
	ecc_evt_t   ecc;
	int         n_mismatch = 0;
	int         checks_done = 0;
	localparam logic [31:0] RD_ADDR [6] = '{32'h0000FFF1, 32'h0000FFF3, 32'h0001FFFE, 32'h0001FFFF,
		32'h0000FFFC, 32'h00010000};
	localparam logic [1:0] RD_SIZE [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2};
	// One wait state: two cycles a beat, plus the taking edge and the edge that sees done.
	localparam int RD_CYC [6] = '{4, 4, 6, 6, 4, 4};

	flash_rd_ecc i_flash_rd_ecc (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rd_req_i(rd_req),
		.rd_done_o(done), .rd_abort_o(abort), .ecc_i(ecc), .force_one_fail_enable_o(f_one),
		.force_zero_fail_enable_o(f_zero), .irq_o(irq_o));
	flash_master_model i_flash_master_model (.clk_i(clk_i), .rd_done_i(done), .rd_abort_i(abort),
		.rd_req_o(rd_req), .ecc_o(ecc));

	// Free-running 250 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	// Reset values, a read-only register and an unmapped address.
	task automatic t_reset;
		rdchk("ctrl", OFS_CTRL, CTRL_RESET);
		rdchk("thresh", OFS_THRESH, {16'h0, THRESH_RESET});
		rdchk("status", OFS_STATUS, 32'h0);
		chk("irq", 32'h0, {31'h0, irq_o});
		wr(8'h1C, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h1C, 32'h0);
		wr(OFS_COUNT, 32'h00001234);
		rdchk("count", OFS_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h00000016);
		chk("force enables", 32'h3, {30'h0, f_zero, f_one});
		wr(OFS_CTRL, CTRL_RESET);
		$display("test reset done");
	endtask

	// Second-bus and first-bus errors outside profiling, with irq masking.
	task automatic t_bus2;
		i_flash_master_model.inject(1'b1, 1'b1, 32'h00020010, 8'h05);
		rdchk("status", OFS_STATUS, 32'h2);
		rdchk("err addr", OFS_ERR_ADDR, 32'h00020010);
		rdchk("err pos", OFS_ERR_POS, 32'h5);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(OFS_MASK, 32'h2);
		chk("irq", 32'h1, {31'h0, irq_o});
		wr(OFS_STATUS, 32'h2);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		i_flash_master_model.inject(1'b0, 1'b0, 32'h00004444, 8'h11);
		rdchk("status", OFS_STATUS, 32'h1);
		rdchk("err addr", OFS_ERR_ADDR, 32'h00004444);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_MASK, 32'h7);
		$display("test bus2 done");
	endtask

	// Profiling with threshold three; the force enables stay clear.
	task automatic t_prof;
		wr(OFS_THRESH, 32'h3);
		wr(OFS_CTRL, 32'h00000011);
		// A first-bus error comes first, so a stale address would show later.
		i_flash_master_model.inject(1'b0, 1'b0, 32'h00030000, 8'h01);
		i_flash_master_model.inject(1'b1, 1'b1, 32'h00030008, 8'h03);
		rdchk("status", OFS_STATUS, 32'h0);
		rdchk("count", OFS_COUNT, 32'h2);
		i_flash_master_model.inject(1'b1, 1'b1, 32'h00012344, 8'h2A);
		rdchk("status", OFS_STATUS, 32'h4);
		chk("irq", 32'h1, {31'h0, irq_o});
		rdchk("err addr", OFS_ERR_ADDR, 32'h00012344);
		rdchk("err pos", OFS_ERR_POS, 32'h2A);
		wr(OFS_CTRL, CTRL_RESET);
		wr(OFS_STATUS, 32'h7);
		rdchk("count", OFS_COUNT, 32'h0);
		chk("irq", 32'h0, {31'h0, irq_o});
		$display("test profiling done");
	endtask

	// Unaligned tail reads, then back-to-back reads across a bank edge.
	task automatic t_reads;
		logic d;
		logic ab;
		int   nc;
		for (int i = 0; i < 6; i++) begin
			i_flash_master_model.read(RD_ADDR[i], RD_SIZE[i], d, ab, nc);
			chk("read done", 32'h1, {31'h0, d});
			chk("read cycles", RD_CYC[i], nc);
			chk("read abort", 32'h0, {31'h0, ab});
		end
		$display("test reads done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence: reset for six cycles, then every scenario.
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_bus2;
		t_prof;
		t_reads;
		results;
	end

	// A hang is cut short well beyond the expected couple of hundred cycles.
	initial begin
		#100000;
		n_mismatch++;
		results;
	end
endmodule
`default_nettype wire
